// ===== logic/socr_regs.sv
/*
 * Serial output configuration registers: master copies written by the
 * serial port, active copies loaded by the transfer bit, and the output
 * word path (pattern substitution, coding, inversion).
 * Assumes the serial port decoder and the sample data source run on clk_in.
 */
// Contract
// - Bit 6 picks standard or low-power LVDS
// - Bit 2 inverts the output data
// - Format 00 offset binary, 01 two's complement
// - Bits 5:4 pick output termination
// - Low nibble picks clock phase, 60-degree steps
// - Phase register resets to 0x03
// - Phase code never touches data timing
// - Pattern low byte held, resets zero
// - Pattern high byte at next address
// - Pattern replaces data in user mode only
// - Transfer bit copies master into active
module socr_regs
  import socr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Register port from serial decoder
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Data path
  input  wire logic [9:0] adc_data_in,
  input  wire logic [3:0] test_mode_in,
  output logic      [9:0] data_out,
  // Driver controls
  output logic            lvds_low_power_out,
  output logic      [1:0] termination_out,
  output logic      [3:0] clock_phase_out
);

  // ----------------------------------------------------------------
  // Master registers
  // ----------------------------------------------------------------
  logic [7:0] fmt_m_q, fmt_m_d;
  logic [7:0] trim_m_q, trim_m_d;
  logic [7:0] phase_m_q, phase_m_d;
  logic [7:0] patl_m_q, patl_m_d;
  logic [7:0] path_m_q, path_m_d;
  logic [7:0] rdata_q, rdata_d;
  logic       xfer;

  assign xfer = reg_wr_in && (reg_addr_in == ADDR_UPDATE) && reg_wdata_in[UPDATE_XFER_BIT];

  always_comb begin
    fmt_m_d   = fmt_m_q;
    trim_m_d  = trim_m_q;
    phase_m_d = phase_m_q;
    patl_m_d  = patl_m_q;
    path_m_d  = path_m_q;
    rdata_d   = rdata_q;
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_OUT_FMT:   fmt_m_d   = reg_wdata_in & MASK_OUT_FMT;
        ADDR_DRV_TRIM:  trim_m_d  = reg_wdata_in & MASK_DRV_TRIM;
        ADDR_CLK_PHASE: phase_m_d = reg_wdata_in & MASK_CLK_PHASE;
        ADDR_PAT1_LOW:  patl_m_d  = reg_wdata_in & MASK_PAT;
        ADDR_PAT1_HIGH: path_m_d  = reg_wdata_in & MASK_PAT;
        default: ;
      endcase
    end
    // Reads show the master copy so software sees what it wrote before a transfer
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_OUT_FMT:   rdata_d = fmt_m_q;
        ADDR_DRV_TRIM:  rdata_d = trim_m_q;
        ADDR_CLK_PHASE: rdata_d = phase_m_q;
        ADDR_PAT1_LOW:  rdata_d = patl_m_q;
        ADDR_PAT1_HIGH: rdata_d = path_m_q;
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fmt_m_q   <= RST_OUT_FMT;
      trim_m_q  <= RST_DRV_TRIM;
      phase_m_q <= RST_CLK_PHASE;
      patl_m_q  <= RST_PAT;
      path_m_q  <= RST_PAT;
      rdata_q   <= 8'h00;
    end else begin
      fmt_m_q   <= fmt_m_d;
      trim_m_q  <= trim_m_d;
      phase_m_q <= phase_m_d;
      patl_m_q  <= patl_m_d;
      path_m_q  <= path_m_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ----------------------------------------------------------------
  // Active registers
  // ----------------------------------------------------------------
  logic [7:0] fmt_a_q, fmt_a_d;
  logic [7:0] trim_a_q, trim_a_d;
  logic [7:0] phase_a_q, phase_a_d;
  logic [7:0] patl_a_q, patl_a_d;
  logic [7:0] path_a_q, path_a_d;

  always_comb begin
    fmt_a_d   = fmt_a_q;
    trim_a_d  = trim_a_q;
    phase_a_d = phase_a_q;
    patl_a_d  = patl_a_q;
    path_a_d  = path_a_q;
    if (xfer) begin
      fmt_a_d   = fmt_m_q;
      trim_a_d  = trim_m_q;
      phase_a_d = phase_m_q;
      patl_a_d  = patl_m_q;
      path_a_d  = path_m_q;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fmt_a_q   <= RST_OUT_FMT;
      trim_a_q  <= RST_DRV_TRIM;
      phase_a_q <= RST_CLK_PHASE;
      patl_a_q  <= RST_PAT;
      path_a_q  <= RST_PAT;
    end else begin
      fmt_a_q   <= fmt_a_d;
      trim_a_q  <= trim_a_d;
      phase_a_q <= phase_a_d;
      patl_a_q  <= patl_a_d;
      path_a_q  <= path_a_d;
    end
  end

  assign lvds_low_power_out = fmt_a_q[FMT_LOW_POWER_BIT];
  assign termination_out    = trim_a_q[TERM_LSB +: 2];
  // Codes above the top step pass through untouched; their phase is undefined
  assign clock_phase_out    = phase_a_q[PHASE_LSB +: 4];

  // ----------------------------------------------------------------
  // Output word path
  // ----------------------------------------------------------------
  // Phase never enters here, so data latching is identical for every phase code
  logic [9:0] data_q, data_d;
  logic [9:0] word;

  always_comb begin
    word = adc_data_in;
    if (test_mode_in == TEST_USER_PAT) begin
      word = {path_a_q[1:0], patl_a_q};
    end else if (fmt_a_q[FMT_CODE_LSB +: 2] == FMT_TWOS_COMP) begin
      word = {~adc_data_in[9], adc_data_in[8:0]};
    end
    data_d = fmt_a_q[FMT_INVERT_BIT] ? ~word : word;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_q <= RST_DATA;
    end else begin
      data_q <= data_d;
    end
  end

  assign data_out = data_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic xfer_seen_q, xfer_seen_d;

  always_comb begin
    xfer_seen_d = xfer_seen_q | xfer;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      xfer_seen_q <= 1'b0;
    end else begin
      xfer_seen_q <= xfer_seen_d;
    end
  end

  chk_phase_reset: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !xfer_seen_q |-> (clock_phase_out == RST_CLK_PHASE[3:0]))
    else $error("Clock phase left its reset code without a transfer");

  chk_xfer_copy: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    xfer |=> (lvds_low_power_out == $past(fmt_m_q[FMT_LOW_POWER_BIT])) &&
             (termination_out == $past(trim_m_q[5:4])) && (clock_phase_out == $past(phase_m_q[3:0])))
    else $error("Transfer did not copy master values");

  chk_active_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !xfer |=> $stable(clock_phase_out) && $stable(termination_out) && $stable(lvds_low_power_out))
    else $error("Active value moved without a transfer");

  chk_pattern_out: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (test_mode_in == TEST_USER_PAT) && !fmt_a_q[FMT_INVERT_BIT] && !xfer
      |=> data_out == {$past(path_a_q[1:0]), $past(patl_a_q)})
    else $error("User pattern not on output");

  chk_offset_out: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (test_mode_in != TEST_USER_PAT) && (fmt_a_q[2:0] == 3'h0) |=> data_out == $past(adc_data_in))
    else $error("Offset binary word altered");

  chk_twos_out: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (test_mode_in != TEST_USER_PAT) && (fmt_a_q[2:0] == 3'h1)
      |=> data_out == {~$past(adc_data_in[9]), $past(adc_data_in[8:0])})
    else $error("Two's complement word wrong");

  chk_invert_out: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (test_mode_in != TEST_USER_PAT) && (fmt_a_q[2:0] == 3'h4) |=> data_out == ~$past(adc_data_in))
    else $error("Inverted word wrong");

  chk_unused_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reg_rd_in && (reg_addr_in == ADDR_CLK_PHASE) |=> reg_rdata_out[7:4] == 4'h0)
    else $error("Unused phase bits read nonzero");

  chk_pat_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reg_wr_in && (reg_addr_in == ADDR_PAT1_HIGH) ##1 reg_rd_in && !reg_wr_in && (reg_addr_in == ADDR_PAT1_HIGH)
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("Pattern high byte not held");

  chk_drive_ctl: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !xfer_seen_q |-> !lvds_low_power_out && (termination_out == TERM_NONE))
    else $error("Driver controls left reset state without a transfer");

  // ----------------------------------------------------------------
  // Register port checks
  // ----------------------------------------------------------------
  // Masked writes: only defined bits may ever hold a one
  chk_fmt_mask: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reg_wr_in && (reg_addr_in == ADDR_OUT_FMT)
      |=> fmt_m_q == ($past(reg_wdata_in) & MASK_OUT_FMT))
    else $error("Format register kept an unused bit");

  chk_trim_mask: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reg_wr_in && (reg_addr_in == ADDR_DRV_TRIM)
      |=> trim_m_q == ($past(reg_wdata_in) & MASK_DRV_TRIM))
    else $error("Drive trim register kept an unused bit");

  chk_phase_mask: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reg_wr_in && (reg_addr_in == ADDR_CLK_PHASE)
      |=> phase_m_q == ($past(reg_wdata_in) & MASK_CLK_PHASE))
    else $error("Phase register kept an unused bit");

  chk_patl_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reg_wr_in && (reg_addr_in == ADDR_PAT1_LOW)
      |=> patl_m_q == $past(reg_wdata_in))
    else $error("Pattern low byte not written");

  chk_path_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reg_wr_in && (reg_addr_in == ADDR_PAT1_HIGH)
      |=> path_m_q == $past(reg_wdata_in))
    else $error("Pattern high byte not written");

  // Masters move only on a write strobe
  chk_master_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !reg_wr_in |=> $stable(fmt_m_q) && $stable(trim_m_q) && $stable(phase_m_q) &&
                   $stable(patl_m_q) && $stable(path_m_q))
    else $error("Master register moved without a write");

  chk_unmapped_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reg_rd_in && (reg_addr_in != ADDR_OUT_FMT) && (reg_addr_in != ADDR_DRV_TRIM) &&
      (reg_addr_in != ADDR_CLK_PHASE) && (reg_addr_in != ADDR_PAT1_LOW) && (reg_addr_in != ADDR_PAT1_HIGH)
      |=> reg_rdata_out == 8'h00)
    else $error("Unmapped address read nonzero");

  // Read data must stand until the next read strobe
  chk_rdata_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("Read data changed without a read");

  chk_xfer_all: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    xfer |=> (fmt_a_q == $past(fmt_m_q)) && (patl_a_q == $past(patl_m_q)) && (path_a_q == $past(path_m_q)))
    else $error("Transfer missed a format or pattern value");

  chk_xfer_bit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reg_wr_in && (reg_addr_in == ADDR_UPDATE) && !reg_wdata_in[UPDATE_XFER_BIT]
      |=> $stable(fmt_a_q) && $stable(patl_a_q) && $stable(path_a_q))
    else $error("Update write without transfer bit moved active values");

  // ----------------------------------------------------------------
  // Output word checks
  // ----------------------------------------------------------------
  // Coding never applies to the pattern, only inversion does
  chk_pattern_raw: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (test_mode_in == TEST_USER_PAT) && (fmt_a_q[2:0] == 3'h1)
      |=> data_out == {$past(path_a_q[1:0]), $past(patl_a_q)})
    else $error("Pattern was recoded");

  chk_pattern_inv: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (test_mode_in == TEST_USER_PAT) && fmt_a_q[FMT_INVERT_BIT]
      |=> data_out == ~{$past(path_a_q[1:0]), $past(patl_a_q)})
    else $error("Inverted pattern wrong");

endmodule : socr_regs

// ===== logic/socr_pkg.sv
/*
 * Constants for the serial output configuration register group:
 * register offsets, field positions, write masks and reset values.
 * Assumes an 8-bit address and 8-bit data register port on the sample clock.
 */
package socr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OUT_FMT   = 8'h14;
  localparam logic [7:0] ADDR_DRV_TRIM  = 8'h15;
  localparam logic [7:0] ADDR_CLK_PHASE = 8'h16;
  localparam logic [7:0] ADDR_PAT1_LOW  = 8'h19;
  localparam logic [7:0] ADDR_PAT1_HIGH = 8'h1a;
  localparam logic [7:0] ADDR_UPDATE    = 8'hff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FMT_LOW_POWER_BIT = 6;
  localparam int FMT_INVERT_BIT    = 2;
  localparam int FMT_CODE_LSB      = 0;
  localparam int TERM_LSB          = 4;
  localparam int PHASE_LSB         = 0;
  localparam int UPDATE_XFER_BIT   = 0;

  // ----------------------------------------------------------------
  // Field codes and masks
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
  localparam logic [1:0] FMT_TWOS_COMP  = 2'h1;
  localparam logic [1:0] TERM_NONE      = 2'h0;
  localparam logic [3:0] PHASE_MAX      = 4'ha;
  localparam logic [3:0] TEST_USER_PAT  = 4'h8;
  localparam logic [7:0] MASK_OUT_FMT   = 8'h47;
  localparam logic [7:0] MASK_DRV_TRIM  = 8'h30;
  localparam logic [7:0] MASK_CLK_PHASE = 8'h0f;
  localparam logic [7:0] MASK_PAT       = 8'hff;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OUT_FMT   = 8'h00;
  localparam logic [7:0] RST_DRV_TRIM  = 8'h00;
  localparam logic [7:0] RST_CLK_PHASE = 8'h03;
  localparam logic [7:0] RST_PAT       = 8'h00;
  localparam logic [9:0] RST_DATA      = 10'h000;

endpackage : socr_pkg

// ===== bench/socr_src_model.sv
/*
 * Sample source model standing in for the converter core.
 * Assumes the bench picks the word; the model drives it at the falling edge.
 */
module socr_src_model
  import socr_pkg::*;
(
  // Clock
  input  wire logic       clk_in,
  // Word chosen by the bench
  input  wire logic [9:0] word_in,
  // Sample stream, offset binary
  output logic      [9:0] adc_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Driven away from the sampling edge so capture never races
  initial adc_data_out = RST_DATA;
  always @(negedge clk_in) begin
    adc_data_out <= word_in;
  end
endmodule : socr_src_model

// ===== bench/tb.sv
/*
 * Bench for the output configuration registers: reset values, masks,
 * transfer, driver controls and output word coding.
 * Assumes the plain strobe register port and a 100 MHz sample clock.
 */
module tb
  import socr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_in       = 1'b0;
  logic       reset_n_in   = 1'b0;
  logic       reg_wr_in    = 1'b0;
  logic       reg_rd_in    = 1'b0;
  logic [7:0] reg_addr_in  = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [3:0] test_mode_in = 4'h0;
  logic [9:0] word         = 10'h000;
  logic [7:0] reg_rdata_out;
  logic [9:0] adc_data_in;
  logic [9:0] data_out;
  logic       lvds_low_power_out;
  logic [1:0] termination_out;
  logic [3:0] clock_phase_out;
  int         bad_count    = 0;
  int         checked      = 0;

  always #5 clk_in = ~clk_in;

  socr_src_model socr_src_model_inst (.clk_in(clk_in), .word_in(word), .adc_data_out(adc_data_in));

  socr_regs socr_regs_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .adc_data_in(adc_data_in), .test_mode_in(test_mode_in), .data_out(data_out),
    .lvds_low_power_out(lvds_low_power_out), .termination_out(termination_out),
    .clock_phase_out(clock_phase_out));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One idle cycle between strobes keeps each a clean single pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask : wr

  // Starts on the current falling edge so a read may follow a write back to back
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    @(negedge clk_in);
    check(10'(reg_rdata_out), 10'(exp));
  endtask : rd

  task automatic dat(input logic [9:0] w, input logic [3:0] m, input logic [9:0] exp);
    @(negedge clk_in);
    word = w;
    test_mode_in = m;
    repeat (2) @(negedge clk_in);
    check(data_out, exp);
  endtask : dat

  task automatic summarize;
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk_in);
    check(10'(clock_phase_out), 10'h003);
    check(10'({lvds_low_power_out, termination_out}), 10'h000);
    reset_n_in = 1'b1;
    rd(ADDR_OUT_FMT, 8'h00);
    rd(ADDR_DRV_TRIM, 8'h00);
    rd(ADDR_CLK_PHASE, 8'h03);
    rd(ADDR_PAT1_LOW, 8'h00);
    rd(ADDR_PAT1_HIGH, 8'h00);
    dat(10'h200, 4'h0, 10'h200);
    wr(ADDR_OUT_FMT, 8'hff);
    wr(ADDR_DRV_TRIM, 8'hff);
    wr(ADDR_CLK_PHASE, 8'hff);
    rd(ADDR_OUT_FMT, 8'h47);
    rd(ADDR_DRV_TRIM, 8'h30);
    rd(ADDR_CLK_PHASE, 8'h0f);
    rd(8'h17, 8'h00);
    rd(ADDR_UPDATE, 8'h00);
    wr(ADDR_UPDATE, 8'hfe);
    @(negedge clk_in);
    check(10'(clock_phase_out), 10'h003);
    wr(ADDR_UPDATE, 8'h01);
    @(negedge clk_in);
    check(10'(clock_phase_out), 10'h00f);
    check(10'({lvds_low_power_out, termination_out}), 10'h007);
    dat(10'h200, 4'h0, 10'h1ff);
    wr(ADDR_OUT_FMT, 8'h01);
    // Phase sweep must leave the data word untouched
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DRV_TRIM, 8'(i << 4));
      wr(ADDR_CLK_PHASE, 8'(3 * i + 1));
      wr(ADDR_UPDATE, 8'h01);
      @(negedge clk_in);
      check(10'(termination_out), 10'(i));
      check(10'(clock_phase_out), 10'(3 * i + 1));
      dat(10'h200, 4'h0, 10'h000);
    end
    dat(10'h2a5, 4'h0, 10'h0a5);
    wr(ADDR_PAT1_LOW, 8'ha5);
    wr(ADDR_PAT1_HIGH, 8'hfe);
    rd(ADDR_PAT1_HIGH, 8'hfe);
    wr(ADDR_OUT_FMT, 8'h04);
    wr(ADDR_UPDATE, 8'h01);
    dat(10'h123, 4'h8, 10'h15a);
    dat(10'h123, 4'h7, 10'h2dc);
    wr(ADDR_OUT_FMT, 8'h01);
    wr(ADDR_UPDATE, 8'h01);
    dat(10'h123, 4'h8, 10'h2a5);
    // Second reset in mid-run
    @(negedge clk_in);
    reset_n_in = 1'b0;
    @(negedge clk_in);
    check(10'(clock_phase_out), 10'h003);
    check(10'({lvds_low_power_out, termination_out}), 10'h000);
    reset_n_in = 1'b1;
    rd(ADDR_PAT1_LOW, 8'h00);
    summarize();
  end
endmodule : tb
